/* tm_pkg.sv */
package tm_pkg;
  // APB register map (byte addresses)
  localparam logic [7:0] ADDR_CMD_OCTET = 8'h00;
  localparam logic [7:0] ADDR_CTRL      = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_CONFIG    = 8'h0C;
  localparam logic [7:0] ADDR_PDU_LEN   = 8'h10;
  localparam logic [7:0] ADDR_PRBS      = 8'h14;
  localparam logic [7:0] ADDR_TX_COUNT  = 8'h18;

  // Message types
  localparam logic [7:0] MSG_GEN_CMD  = 8'h24;
  localparam logic [7:0] MSG_LOOP_CMD = 8'h25;

  // Field positions
  localparam int LEN_SEL_BIT  = 7;
  localparam int MODE_BIT     = 0;
  localparam int TS_LSB       = 1;
  localparam int TS_MSB       = 3;
  localparam int CNT_HI_MSB   = 3;

  localparam logic [10:0] PDU_LEN_MIN = 11'h08C;
  localparam logic [10:0] PDU_LEN_MAX = 11'h618;
  localparam logic [10:0] PDU_LEN_RST = 11'h08C;
  localparam logic [11:0] CNT_MAX     = 12'hFFF;
  localparam logic [15:0] PRBS_SEED   = 16'hACE1;
  localparam logic [15:0] PRBS_TAPS   = 16'hB400;

  typedef enum logic [4:0] {
    PS_IDLE = 5'b00001,
    PS_TYPE = 5'b00010,
    PS_DESC = 5'b00100,
    PS_CNT  = 5'b01000,
    PS_MODE = 5'b10000
  } parse_state_t;

  typedef struct packed {
    logic        genActive;
    logic        loopActive;
    logic        gmskOnly;
    logic        unlimited;
    logic [2:0]  timeslot;
    logic [11:0] pduCount;
  } test_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } octet_t;
endpackage

/* prbs_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module prbs_gen #(
  parameter logic [15:0] SEED = 16'hACE1,
  parameter logic [15:0] TAPS = 16'hB400
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        restart,
  input  wire logic        advance,
  output logic [7:0]       octet
);
  typedef struct packed {
    logic [15:0] lfsr;
  } prbs_state_t;

  prbs_state_t s_q;
  prbs_state_t s_d;

  always_comb begin
    logic [15:0] v;
    v = s_q.lfsr;
    s_d = s_q;
    if (restart) begin
      s_d.lfsr = SEED;
    end else if (advance) begin
      for (int i = 0; i < 8; i++) begin
        v = v[0] ? ((v >> 1) ^ TAPS) : (v >> 1);
      end
      s_d.lfsr = v;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{lfsr: SEED};
    end else begin
      s_q <= s_d;
    end
  end

  assign octet = s_q.lfsr[7:0];
endmodule
`default_nettype wire

/* test_mode_command_decoder.sv */
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module test_mode_command_decoder
  import tm_pkg::*;
#(
  parameter bit BOTH_OPTIONS  = 1'b1,
  parameter bit ZERO_UNLIMIT  = 1'b1,
  parameter bit UL_8PSK_CAPABLE = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxWide,
  input  wire logic        pduOctetTake,
  output logic [7:0]       pduOctet,
  output logic             pduOctetValid,
  output logic             pduLast,
  output logic             genActive,
  output logic             loopActive,
  output logic             txWide,
  output logic [2:0]       timeslot
);
  import tm_pkg::*;

  initial begin
    if (!BOTH_OPTIONS && ZERO_UNLIMIT === 1'bx) begin
      $error("bad parameters");
    end
  end

  typedef struct packed {
    parse_state_t ps;
    logic [7:0]   descHi;
    logic [11:0]  cntTmp;
    logic         gen;
    test_cfg_t    cfg;
    logic [10:0]  pduLen;
    logic [10:0]  octIdx;
    logic [11:0]  sent;
    logic         cmdDone;
    logic         badLen;
    logic         badType;
    logic [31:0]  rdata;
    logic         ready;
    logic         slverr;
    logic         outValid;
    logic         outLast;
    logic         outWide;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic [7:0] prbsOctet;
  logic       prbsRestart;
  logic       prbsAdvance;
  logic       access;
  logic       wrOctet;

  assign access  = psel && penable && !s_q.ready;
  assign wrOctet = access && pwrite && (paddr == ADDR_CMD_OCTET);

  prbs_gen #(
    .SEED (PRBS_SEED),
    .TAPS (PRBS_TAPS)
  ) u_prbs (
    .clk     (clk),
    .rst     (rst),
    .restart (prbsRestart),
    .advance (prbsAdvance),
    .octet   (prbsOctet)
  );

  always_comb begin
    logic [7:0]  o;
    logic        lastOct;
    logic        lastPdu;
    o = pwdata[7:0];
    lastOct = (s_q.octIdx == s_q.pduLen - 11'h001);
    lastPdu = !s_q.cfg.unlimited && (s_q.sent == s_q.cfg.pduCount - 12'h001);
    s_d = s_q;
    prbsRestart = 1'b0;
    prbsAdvance = 1'b0;
    s_d.ready = access;
    s_d.slverr = 1'b0;
    s_d.rdata = '0;
    if (access) begin
      if (pwrite) begin
        if (paddr == ADDR_CMD_OCTET) begin
        end else if (paddr == ADDR_CTRL) begin
          if (pwdata[0]) begin
            s_d.ps = PS_IDLE;
          end
          if (pwdata[1]) begin
            s_d.cfg.genActive = 1'b0;
            s_d.cfg.loopActive = 1'b0;
          end
          if (pwdata[2]) begin
            s_d.cmdDone = 1'b0;
            s_d.badLen = 1'b0;
            s_d.badType = 1'b0;
          end
        end else if (paddr == ADDR_PDU_LEN) begin
          // Length is clamped into the legal span
          if (pwdata[10:0] < PDU_LEN_MIN) begin
            s_d.pduLen = PDU_LEN_MIN;
          end else if (pwdata[10:0] > PDU_LEN_MAX) begin
            s_d.pduLen = PDU_LEN_MAX;
          end else begin
            s_d.pduLen = pwdata[10:0];
          end
        end else begin
          s_d.slverr = 1'b1;
        end
      end else begin
        if (paddr == ADDR_STATUS) begin
          s_d.rdata = {27'h000_0000, s_q.badType, s_q.badLen, s_q.cmdDone,
                       s_q.cfg.loopActive, s_q.cfg.genActive};
        end else if (paddr == ADDR_CONFIG) begin
          s_d.rdata = {14'h0000, s_q.cfg.unlimited, s_q.cfg.gmskOnly,
                       s_q.cfg.timeslot, 1'b0, s_q.cfg.pduCount};
        end else if (paddr == ADDR_PDU_LEN) begin
          s_d.rdata = {21'h00_0000, s_q.pduLen};
        end else if (paddr == ADDR_PRBS) begin
          s_d.rdata = {24'h00_0000, prbsOctet};
        end else if (paddr == ADDR_TX_COUNT) begin
          s_d.rdata = {20'h0_0000, s_q.sent};
        end else if (paddr == ADDR_CMD_OCTET || paddr == ADDR_CTRL) begin
          s_d.rdata = '0;
        end else begin
          s_d.slverr = 1'b1;
        end
      end
    end
    if (wrOctet) begin
      case (s_q.ps)
        PS_IDLE: begin
          s_d.ps = PS_TYPE;
        end
        PS_TYPE: begin
          if (o == MSG_GEN_CMD) begin
            s_d.gen = 1'b1;
            s_d.ps = PS_DESC;
          end else if (o == MSG_LOOP_CMD) begin
            s_d.gen = 1'b0;
            s_d.ps = PS_MODE;
          end else begin
            s_d.badType = 1'b1;
            s_d.ps = PS_IDLE;
          end
        end
        PS_DESC: begin
          s_d.descHi = o;
          s_d.ps = PS_CNT;
        end
        PS_CNT: begin
          // Upper nibble then low byte; spare bits dropped
          s_d.cntTmp = {s_q.descHi[CNT_HI_MSB:0], o};
          s_d.ps = PS_MODE;
        end
        PS_MODE: begin
          s_d.ps = PS_IDLE;
          if (s_q.gen && !s_q.descHi[LEN_SEL_BIT]) begin
            s_d.badLen = 1'b1;
          end else if (s_q.gen && s_q.cntTmp == 12'h000 && !ZERO_UNLIMIT) begin
            s_d.badLen = 1'b1;
          end else begin
            s_d.cmdDone = 1'b1;
            s_d.cfg.timeslot = o[TS_MSB:TS_LSB];
            s_d.sent = '0;
            s_d.octIdx = '0;
            prbsRestart = 1'b1;
            if (s_q.gen) begin
              s_d.cfg.pduCount = s_q.cntTmp;
              s_d.cfg.unlimited = (s_q.cntTmp == 12'h000);
              // No forced modulation left from a loopback command
              s_d.cfg.gmskOnly = 1'b0;
              s_d.cfg.genActive = !(BOTH_OPTIONS && o[MODE_BIT]);
              s_d.cfg.loopActive = BOTH_OPTIONS && o[MODE_BIT];
            end else begin
              s_d.cfg.genActive = 1'b0;
              s_d.cfg.loopActive = 1'b1;
              s_d.cfg.gmskOnly = o[MODE_BIT] && !UL_8PSK_CAPABLE;
            end
          end
        end
        default: begin
          s_d.ps = PS_IDLE;
        end
      endcase
    end
    // Output octets are pure sequence, no framing added
    if (s_q.cfg.genActive) begin
      s_d.outValid = 1'b1;
      s_d.outLast = lastOct;
      if (s_q.outValid && pduOctetTake) begin
        prbsAdvance = 1'b1;
        if (lastOct) begin
          // Next octet opens a fresh PDU, never its last
          s_d.octIdx = '0;
          s_d.outLast = 1'b0;
          if (lastPdu) begin
            s_d.cfg.genActive = 1'b0;
            s_d.outValid = 1'b0;
          end else begin
            s_d.sent = s_q.sent + 12'h001;
          end
        end else begin
          s_d.octIdx = s_q.octIdx + 11'h001;
          s_d.outLast = (s_q.octIdx + 11'h001 == s_q.pduLen - 11'h001);
        end
      end
    end else begin
      s_d.outValid = 1'b0;
      s_d.outLast = 1'b0;
    end
    // In loopback, uplink modulation follows received one unless forced; outside loopback txWide is 0
    s_d.outWide = s_q.cfg.loopActive && !s_q.cfg.gmskOnly && rxWide;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{ps: PS_IDLE, pduLen: PDU_LEN_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata        = s_q.rdata;
  assign pready        = s_q.ready;
  assign pslverr       = s_q.slverr;
  assign pduOctet      = prbsOctet;
  assign pduOctetValid = s_q.outValid;
  assign pduLast       = s_q.outLast;
  assign genActive     = s_q.cfg.genActive;
  assign loopActive    = s_q.cfg.loopActive;
  assign txWide        = s_q.outWide;
  assign timeslot      = s_q.cfg.timeslot;

  property p_len_clamp;
    @(posedge clk) disable iff (rst)
      (s_q.pduLen >= PDU_LEN_MIN) && (s_q.pduLen <= PDU_LEN_MAX);
  endproperty
  a_len_clamp: assert property (p_len_clamp) else $error("len out of range");

  property p_ts;
    @(posedge clk) disable iff (rst)
      wrOctet && s_q.ps == PS_MODE && !s_q.gen |=> timeslot == $past(pwdata[3:1]);
  endproperty
  a_ts: assert property (p_ts) else $error("timeslot wrong");

  property p_reserved;
    @(posedge clk) disable iff (rst)
      wrOctet && s_q.ps == PS_MODE && s_q.gen && !s_q.descHi[7]
      |=> $stable(s_q.cfg);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved changed cfg");

  property p_loop_type;
    @(posedge clk) disable iff (rst)
      wrOctet && s_q.ps == PS_TYPE && pwdata[7:0] == MSG_LOOP_CMD
      |=> s_q.ps == PS_MODE;
  endproperty
  a_loop_type: assert property (p_loop_type) else $error("type decode");

  property p_gmsk;
    @(posedge clk) disable iff (rst)
      s_q.cfg.gmskOnly |=> !txWide;
  endproperty
  a_gmsk: assert property (p_gmsk) else $error("wide while forced");

  property p_follow;
    @(posedge clk) disable iff (rst)
      s_q.cfg.loopActive && !s_q.cfg.gmskOnly |=> txWide == $past(rxWide);
  endproperty
  a_follow: assert property (p_follow) else $error("no follow");

  property p_excl;
    @(posedge clk) disable iff (rst) !(genActive && loopActive);
  endproperty
  a_excl: assert property (p_excl) else $error("both modes");

  property p_src1;
    @(posedge clk) disable iff (rst)
      wrOctet && s_q.ps == PS_MODE && s_q.gen && s_q.descHi[7] && pwdata[0]
      && s_q.cntTmp != 12'h000 |=> loopActive && !genActive;
  endproperty
  a_src1: assert property (p_src1) else $error("src bit");

  property p_count;
    @(posedge clk) disable iff (rst)
      !s_q.cfg.unlimited && genActive |-> s_q.sent < s_q.cfg.pduCount;
  endproperty
  a_count: assert property (p_count) else $error("too many pdus");
endmodule
`default_nettype wire

/* pdu_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module pdu_sink (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic armed,
  input  wire logic valid,
  input  wire logic last,
  output logic      take,
  output int        pdus,
  output int        lastLen,
  output int        waitCyc
);
  int cnt;
  logic seen;
  // Consumer stalls every other cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      take <= 1'b0;
      pdus <= 0;
      lastLen <= 0;
      cnt <= 0;
      seen <= 1'b0;
      waitCyc <= 0;
    end else begin
      take <= ~take;
      // Supervision time until first uplink octet
      if (!armed) begin
        seen <= 1'b0;
        waitCyc <= 0;
      end else if (!seen) begin
        waitCyc <= waitCyc + 1;
      end
      if (valid && take) begin
        seen <= 1'b1;
        cnt <= last ? 0 : cnt + 1;
        if (last) begin
          pdus <= pdus + 1;
          lastLen <= cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test_mode_command_decoder_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module test_mode_command_decoder_bench;
  import tm_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        rxWide;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] cfg;
  logic        pready;
  logic        pslverr;
  logic        er;
  logic [7:0]  pduOctet;
  logic        pduOctetValid;
  logic        pduLast;
  logic        genActive;
  logic        loopActive;
  logic        txWide;
  logic        take;
  logic [2:0]  timeslot;
  int          pdus;
  int          lastLen;
  int          mismatches;
  int          checks_done;

  test_mode_command_decoder dut (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxWide(rxWide),
    .pduOctetTake(take), .pduOctet(pduOctet),
    .pduOctetValid(pduOctetValid), .pduLast(pduLast),
    .genActive(genActive), .loopActive(loopActive), .txWide(txWide),
    .timeslot(timeslot));
  pdu_sink sink (.clk(clk), .rst(rst), .armed(genActive | loopActive),
    .valid(pduOctetValid), .last(pduLast), .take(take), .pdus(pdus),
    .lastLen(lastLen), .waitCyc());

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic final_report;
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Discriminator, type, optional description, mode
  task automatic cmd(input logic [7:0] t, input logic [15:0] desc,
                     input logic [7:0] m);
    apb(1'b1, ADDR_CMD_OCTET, 32'h0000_000F);
    apb(1'b1, ADDR_CMD_OCTET, {24'h0, t});
    if (t == MSG_GEN_CMD) begin
      apb(1'b1, ADDR_CMD_OCTET, {24'h0, desc[15:8]});
      apb(1'b1, ADDR_CMD_OCTET, {24'h0, desc[7:0]});
    end
    if (t == MSG_GEN_CMD || t == MSG_LOOP_CMD)
      apb(1'b1, ADDR_CMD_OCTET, {24'h0, m});
    apb(1'b0, ADDR_STATUS, 32'h0);
  endtask

  task automatic t_reset;
    chk({genActive, loopActive, txWide, pduOctetValid}, 4'h0);
    apb(1'b0, ADDR_PDU_LEN, 32'h0);
    chk(rd, 32'h0000_008C);
    apb(1'b0, 8'h1C, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, ADDR_PDU_LEN, 32'h0000_0064);
    apb(1'b0, ADDR_PDU_LEN, 32'h0);
    chk(rd, 32'h0000_008C);
    apb(1'b1, ADDR_PDU_LEN, 32'h0000_07D0);
    apb(1'b0, ADDR_PDU_LEN, 32'h0);
    chk(rd, 32'h0000_0618);
    apb(1'b1, ADDR_PDU_LEN, 32'h0000_008C);
  endtask

  task automatic t_gen;
    int base;
    int i;
    base = pdus;
    // Spare bits set on purpose, count 2, offset 5
    cmd(MSG_GEN_CMD, 16'hF002, 8'hFA);
    chk(rd[2], 1'b1);
    chk({genActive, loopActive}, 2'b10);
    chk(timeslot, 3'd5);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd[17:0], 18'h0A002);
    for (i = 0; i < 3000 && pdus < base + 2; i++)
      @(posedge clk);
    chk(pdus, base + 2);
    chk(lastLen, 140);
    repeat (4) @(posedge clk);
    chk(pduOctetValid, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0006);
  endtask

  task automatic t_loop;
    logic m;
    for (int k = 0; k < 2; k++) begin
      m = k[0];
      cmd(MSG_LOOP_CMD, 16'h0, {7'h07, m});
      chk({loopActive, genActive, timeslot}, 5'b10111);
      rxWide <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(txWide, m ? 1'b0 : 1'b1);
      rxWide <= 1'b0;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(txWide, 1'b0);
      apb(1'b1, ADDR_CTRL, 32'h0000_0006);
    end
    // Count zero with loop source selected
    cmd(MSG_GEN_CMD, 16'h8000, 8'h01);
    chk({loopActive, genActive}, 2'b10);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd & 32'h0002_EFFF, 32'h0002_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_0006);
  endtask

  task automatic t_bad;
    apb(1'b0, ADDR_CONFIG, 32'h0);
    cfg = rd;
    cmd(MSG_GEN_CMD, 16'h0555, 8'h04);
    chk(rd[3], 1'b1);
    chk(genActive, 1'b0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(rd, cfg);
    cmd(8'h26, 16'h0, 8'h0);
    chk(rd[4], 1'b1);
    chk({genActive, loopActive}, 2'b00);
  endtask

  initial begin
    mismatches = 0;
    checks_done = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rxWide = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_gen();
    t_loop();
    t_bad();
    final_report();
  end
endmodule
`default_nettype wire
